// ### rtl/pmbscr_regs.sv
`timescale 1ns/1ns
// How it works
// [R1] Temperature status: over-temp fault bit7, warning bit6
// [R2] Comm status: bad command, bad data, PEC fail
// [R3] Module type bit1 is write protect enable
// [R4] Write protect locks all calibration word writes
// [R5] Designation bits 7:2, isolated MSB always one
// [R6] Gain words accept 0x1999 to 0x2666 only
// [R7] Offset words need fixed exponent, else rejected
// [R8] Firmware revision is read-only eight-bit value
// [R9] Pin config bit4 selects alert response address
// [R10] Pin config 3:0 assigns both control pins
// [R11] Load-share variant supports only pin code 0000
// [R12] Combine bit1: ignore secondary or AND both
// [R13] Combine bit0: secondary enable polarity, default low
// [R14] Power-ok polarity bit0 sets pin level, default 1
// [R15] Reserved upper bits read zero, not writable
// [R16] Unsupported bits read zero; flags stick until cleared
// [R17] Host unlocks protection and writes legal values
module pmbscr_regs #(
  parameter bit         LOAD_SHARE  = 1'b0,
  parameter logic [5:0] DESIGNATION = 6'h2a, // Arbitrary value
  parameter logic [7:0] FW_REVISION = 8'h11  // Arbitrary value
) (
  // Core clock and control
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        en_i,
  // Link side
  input  wire logic        link_clk_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic        cmd_write_i,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic        cmd_pec_ok_i,
  output logic             rsp_valid_o,
  output logic [15:0]      rsp_data_o,
  output logic             link_busy_o,
  // Measurements and events
  input  wire logic [15:0] vin_meas_i,
  input  wire logic [15:0] vout_meas_i,
  input  wire logic [15:0] iout_meas_i,
  input  wire logic [15:0] temp_meas_i,
  input  wire logic        ot_fault_evt_i,
  input  wire logic        ot_warn_evt_i,
  input  wire logic        power_ok_i,
  input  wire logic        alert_i,
  // Pins
  input  wire logic        primary_on_i,
  input  wire logic        first_control_pin_i,
  input  wire logic        second_control_pin_i,
  output logic             second_control_pin_o,
  output logic             second_control_pin_oe_o,
  // Derived outputs
  output logic             output_on_o,
  output logic             ara_only_o,
  output logic [15:0]      vout_gain_o,
  output logic [15:0]      vin_gain_o,
  output logic [15:0]      iout_gain_o
);
  import pmbscr_pkg::*;

  typedef enum logic [0:0] {LINK_IDLE, LINK_WAIT} pmbscr_link_st_t;

  typedef struct packed {
    pmbscr_link_st_t state;
    logic            req_tgl;
    logic [7:0]      code;
    logic            write;
    logic [15:0]     data;
    logic            pec_ok;
    logic [1:0]      ack_sync;
    logic            ack_seen;
    logic            rsp_valid;
    logic [15:0]     rsp_data;
  } pmbscr_link_t;

  typedef struct packed {
    logic [2:0]  pri_sync;
    logic [2:0]  c1_sync;
    logic [2:0]  c2_sync;
    logic        pri;
    logic        c1;
    logic        c2;
    logic [1:0]  req_sync;
    logic        req_seen;
    logic        ack_tgl;
    logic [15:0] rsp_data;
    logic        ot_fault;
    logic        ot_warn;
    logic        bad_cmd;
    logic        bad_data;
    logic        pec_fail;
    logic        wp_on;
    logic [15:0] vout_gain;
    logic [15:0] vout_off;
    logic [15:0] vin_gain;
    logic [15:0] vin_off;
    logic [15:0] iout_gain;
    logic [15:0] iout_off;
    logic [4:0]  pin_cfg;
    logic [1:0]  onoff;
    logic        pg_pol;
    logic        output_on;
    logic        pg_level;
    logic        pg_oe;
    logic        ara_only;
  } pmbscr_core_t;

  localparam logic [15:0] VOUT_OFF_RESET = {EXP_VOUT, OFFSET_MANT_RESET};
  localparam logic [15:0] VIN_OFF_RESET  = {EXP_VIN, OFFSET_MANT_RESET};
  localparam logic [15:0] IOUT_OFF_RESET = {EXP_IOUT, OFFSET_MANT_RESET};

  function automatic logic gain_ok(input logic [15:0] v);
    gain_ok = (v >= GAIN_MIN) && (v <= GAIN_MAX);
  endfunction

  function automatic logic exp_ok(input logic [15:0] v, input logic [4:0] e);
    exp_ok = (v[15:11] == e);
  endfunction

  function automatic logic pins_ok(input logic [3:0] v);
    if (LOAD_SHARE) begin
      pins_ok = (v == PINS_ONOFF_PG);
    end else begin
      pins_ok = (v == PINS_ONOFF_PG) || (v == PINS_TRIM_PG) || (v == PINS_TRIM_ONOFF);
    end
  endfunction

  pmbscr_link_t lk_q, lk_d;
  pmbscr_core_t cr_q, cr_d;
  logic         handle;

  // Link domain: capture a command and wait for the core to answer
  always_comb begin
    lk_d = lk_q;
    lk_d.ack_sync = {lk_q.ack_sync[0], cr_q.ack_tgl};
    lk_d.rsp_valid = 1'b0;
    case (lk_q.state)
      LINK_IDLE: begin
        if (cmd_valid_i) begin
          lk_d.code = cmd_code_i;
          lk_d.write = cmd_write_i;
          lk_d.data = cmd_data_i;
          lk_d.pec_ok = cmd_pec_ok_i;
          lk_d.req_tgl = ~lk_q.req_tgl;
          lk_d.state = LINK_WAIT;
        end
      end
      LINK_WAIT: begin
        if (lk_q.ack_sync[1] != lk_q.ack_seen) begin
          lk_d.ack_seen = lk_q.ack_sync[1];
          lk_d.rsp_valid = 1'b1;
          lk_d.rsp_data = cr_q.rsp_data;
          lk_d.state = LINK_IDLE;
        end
      end
      default: lk_d.state = LINK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  assign handle = en_i && (cr_q.req_sync[1] != cr_q.req_seen);

  // Core domain: pins, command execution, status flags
  always_comb begin
    logic [7:0] t_clr;
    logic [7:0] c_clr;
    logic       set_cmd;
    logic       set_data;
    logic       set_pec;
    logic       sec_true;
    logic       sec_pin;
    logic       pg_drive;
    t_clr = 8'h00;
    c_clr = 8'h00;
    set_cmd = 1'b0;
    set_data = 1'b0;
    set_pec = 1'b0;
    sec_true = 1'b0;
    sec_pin = 1'b0;
    pg_drive = 1'b0;
    cr_d = cr_q;
    cr_d.pri_sync = {cr_q.pri_sync[1:0], primary_on_i};
    cr_d.c1_sync = {cr_q.c1_sync[1:0], first_control_pin_i};
    cr_d.c2_sync = {cr_q.c2_sync[1:0], second_control_pin_i};
    if (cr_q.pri_sync[1] == cr_q.pri_sync[2]) begin
      cr_d.pri = cr_q.pri_sync[2];
    end
    if (cr_q.c1_sync[1] == cr_q.c1_sync[2]) begin
      cr_d.c1 = cr_q.c1_sync[2];
    end
    if (cr_q.c2_sync[1] == cr_q.c2_sync[2]) begin
      cr_d.c2 = cr_q.c2_sync[2];
    end
    cr_d.req_sync = {cr_q.req_sync[0], lk_q.req_tgl};
    if (handle) begin
      cr_d.req_seen = cr_q.req_sync[1];
      cr_d.ack_tgl = ~cr_q.ack_tgl;
      cr_d.rsp_data = 16'h0000;
      if (lk_q.write && !lk_q.pec_ok) begin
        set_pec = 1'b1; // [R2]
      end else begin
        case (lk_q.code)
          CMD_TEMP_STATUS: begin
            if (lk_q.write) begin
              t_clr = lk_q.data[7:0]; // [R16]
            end
            cr_d.rsp_data[TEMP_OT_FAULT_BIT] = cr_q.ot_fault; // [R1]
            cr_d.rsp_data[TEMP_OT_WARN_BIT] = cr_q.ot_warn; // [R1]
          end
          CMD_COMM_STATUS: begin
            if (lk_q.write) begin
              c_clr = lk_q.data[7:0]; // [R16]
            end
            cr_d.rsp_data[COMM_BAD_CMD_BIT] = cr_q.bad_cmd; // [R2]
            cr_d.rsp_data[COMM_BAD_DATA_BIT] = cr_q.bad_data; // [R2]
            cr_d.rsp_data[COMM_PEC_FAIL_BIT] = cr_q.pec_fail; // [R2]
          end
          CMD_VIN_READING, CMD_VOUT_READING, CMD_IOUT_READING, CMD_TEMP_READING,
          CMD_FW_REVISION: begin
            if (lk_q.write) begin
              set_cmd = 1'b1; // [R8]
            end else if (lk_q.code == CMD_VIN_READING) begin
              cr_d.rsp_data = vin_meas_i;
            end else if (lk_q.code == CMD_VOUT_READING) begin
              cr_d.rsp_data = vout_meas_i;
            end else if (lk_q.code == CMD_IOUT_READING) begin
              cr_d.rsp_data = iout_meas_i;
            end else if (lk_q.code == CMD_TEMP_READING) begin
              cr_d.rsp_data = temp_meas_i;
            end else begin
              cr_d.rsp_data = {8'h00, FW_REVISION}; // [R8]
            end
          end
          CMD_MODULE_TYPE: begin
            if (lk_q.write) begin
              cr_d.wp_on = lk_q.data[WP_BIT]; // [R3]
            end
            cr_d.rsp_data = {8'h00, 1'b1, DESIGNATION[4:0], cr_q.wp_on, 1'b0}; // [R5]
          end
          CMD_VOUT_GAIN, CMD_VIN_GAIN, CMD_IOUT_GAIN: begin
            if (lk_q.write) begin
              if (cr_q.wp_on || !gain_ok(lk_q.data)) begin
                set_data = 1'b1; // [R4]
              end else if (lk_q.code == CMD_VOUT_GAIN) begin
                cr_d.vout_gain = lk_q.data; // [R6]
              end else if (lk_q.code == CMD_VIN_GAIN) begin
                cr_d.vin_gain = lk_q.data; // [R6]
              end else begin
                cr_d.iout_gain = lk_q.data; // [R6]
              end
            end
            if (lk_q.code == CMD_VOUT_GAIN) begin
              cr_d.rsp_data = cr_q.vout_gain;
            end else if (lk_q.code == CMD_VIN_GAIN) begin
              cr_d.rsp_data = cr_q.vin_gain;
            end else begin
              cr_d.rsp_data = cr_q.iout_gain;
            end
          end
          CMD_VOUT_OFFSET: begin
            if (lk_q.write) begin
              if (cr_q.wp_on || !exp_ok(lk_q.data, EXP_VOUT)) begin
                set_data = 1'b1; // [R7]
              end else begin
                cr_d.vout_off = lk_q.data;
              end
            end
            cr_d.rsp_data = cr_q.vout_off;
          end
          CMD_VIN_OFFSET: begin
            if (lk_q.write) begin
              if (cr_q.wp_on || !exp_ok(lk_q.data, EXP_VIN)) begin
                set_data = 1'b1; // [R7]
              end else begin
                cr_d.vin_off = lk_q.data;
              end
            end
            cr_d.rsp_data = cr_q.vin_off;
          end
          CMD_IOUT_OFFSET: begin
            if (lk_q.write) begin
              if (cr_q.wp_on || !exp_ok(lk_q.data, EXP_IOUT)) begin
                set_data = 1'b1; // [R7]
              end else begin
                cr_d.iout_off = lk_q.data;
              end
            end
            cr_d.rsp_data = cr_q.iout_off;
          end
          CMD_PIN_CONFIG: begin
            if (lk_q.write) begin
              if (pins_ok(lk_q.data[3:0])) begin
                cr_d.pin_cfg = lk_q.data[4:0]; // [R15]
              end else begin
                set_data = 1'b1; // [R11]
              end
            end
            cr_d.rsp_data = {11'h000, cr_q.pin_cfg}; // [R15]
          end
          CMD_ONOFF_COMBINE: begin
            if (lk_q.write) begin
              cr_d.onoff = lk_q.data[1:0]; // [R15]
            end
            cr_d.rsp_data = {14'h0000, cr_q.onoff}; // [R15]
          end
          CMD_POWER_OK_POL: begin
            if (lk_q.write) begin
              cr_d.pg_pol = lk_q.data[0]; // [R14]
            end
            cr_d.rsp_data = {15'h0000, cr_q.pg_pol}; // [R14]
          end
          default: set_cmd = 1'b1; // [R2]
        endcase
      end
      // Writes answer with an empty word
      if (lk_q.write) begin
        cr_d.rsp_data = 16'h0000;
      end
    end
    // Set wins over a clear in the same cycle
    cr_d.ot_fault = (cr_q.ot_fault & ~t_clr[TEMP_OT_FAULT_BIT]) | ot_fault_evt_i; // [R1]
    cr_d.ot_warn = (cr_q.ot_warn & ~t_clr[TEMP_OT_WARN_BIT]) | ot_warn_evt_i; // [R1]
    cr_d.bad_cmd = (cr_q.bad_cmd & ~c_clr[COMM_BAD_CMD_BIT]) | set_cmd; // [R16]
    cr_d.bad_data = (cr_q.bad_data & ~c_clr[COMM_BAD_DATA_BIT]) | set_data; // [R16]
    cr_d.pec_fail = (cr_q.pec_fail & ~c_clr[COMM_PEC_FAIL_BIT]) | set_pec; // [R16]
    // Pin roles and enable combination
    sec_pin = (cr_q.pin_cfg[3:0] == PINS_TRIM_ONOFF) ? cr_q.c2 : cr_q.c1; // [R10]
    sec_true = cr_q.onoff[ONOFF_POL_BIT] ? sec_pin : ~sec_pin; // [R13]
    if (cr_q.pin_cfg[3:0] == PINS_TRIM_PG) begin
      sec_true = 1'b1;
    end
    cr_d.output_on = cr_q.pri & (~cr_q.onoff[ONOFF_AND_BIT] | sec_true); // [R12]
    pg_drive = (cr_q.pin_cfg[3:0] != PINS_TRIM_ONOFF); // [R10]
    cr_d.pg_oe = pg_drive;
    cr_d.pg_level = cr_q.pg_pol ? power_ok_i : ~power_ok_i; // [R14]
    cr_d.ara_only = cr_q.pin_cfg[ARA_BIT] & alert_i; // [R9]
    if (!en_i) begin
      cr_d = cr_q;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cr_q <= '0;
      cr_q.wp_on <= WP_RESET;
      cr_q.vout_gain <= GAIN_RESET;
      cr_q.vin_gain <= GAIN_RESET;
      cr_q.iout_gain <= GAIN_RESET;
      cr_q.vout_off <= VOUT_OFF_RESET;
      cr_q.vin_off <= VIN_OFF_RESET;
      cr_q.iout_off <= IOUT_OFF_RESET;
      cr_q.pin_cfg <= PIN_CFG_RESET;
      cr_q.onoff <= ONOFF_RESET;
      cr_q.pg_pol <= PG_POL_RESET;
    end else begin
      cr_q <= cr_d;
    end
  end

  assign rsp_valid_o = lk_q.rsp_valid;
  assign rsp_data_o = lk_q.rsp_data;
  assign link_busy_o = (lk_q.state == LINK_WAIT);
  assign second_control_pin_o = cr_q.pg_level;
  assign second_control_pin_oe_o = cr_q.pg_oe;
  assign output_on_o = cr_q.output_on;
  assign ara_only_o = cr_q.ara_only;
  assign vout_gain_o = cr_q.vout_gain;
  assign vin_gain_o = cr_q.vin_gain;
  assign iout_gain_o = cr_q.iout_gain;

  sequence s_write(logic [7:0] c);
    handle && lk_q.write && lk_q.pec_ok && (lk_q.code == c);
  endsequence

  sequence s_read(logic [7:0] c);
    handle && !lk_q.write && (lk_q.code == c);
  endsequence

  property p_temp_read;
    @(posedge clk_i) disable iff (reset_i)
      s_read(CMD_TEMP_STATUS) |=> (cr_q.rsp_data[5:0] == 6'h00);
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("temp status low bits set"); // [R1]

  property p_pec_fail;
    @(posedge clk_i) disable iff (reset_i)
      (handle && lk_q.write && !lk_q.pec_ok) |=> cr_q.pec_fail;
  endproperty
  a_pec_fail: assert property (p_pec_fail) else $error("pec fail not flagged"); // [R2]

  property p_wp_lock;
    @(posedge clk_i) disable iff (reset_i)
      (s_write(CMD_VOUT_GAIN) and (cr_q.wp_on == 1'b1)) |=> $stable(cr_q.vout_gain);
  endproperty
  a_wp_lock: assert property (p_wp_lock) else $error("gain written while protected"); // [R4]

  property p_desig;
    @(posedge clk_i) disable iff (reset_i)
      s_read(CMD_MODULE_TYPE) |=> (cr_q.rsp_data[7] && (cr_q.rsp_data[1] == $past(cr_q.wp_on)));
  endproperty
  a_desig: assert property (p_desig) else $error("module type word wrong"); // [R5]

  property p_gain_range;
    @(posedge clk_i) disable iff (reset_i)
      gain_ok(cr_q.vout_gain) && gain_ok(cr_q.vin_gain) && gain_ok(cr_q.iout_gain);
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain out of range"); // [R6]

  property p_exp;
    @(posedge clk_i) disable iff (reset_i)
      exp_ok(cr_q.vout_off, EXP_VOUT) && exp_ok(cr_q.vin_off, EXP_VIN);
  endproperty
  a_exp: assert property (p_exp) else $error("offset exponent wrong"); // [R7]

  property p_fw_ro;
    @(posedge clk_i) disable iff (reset_i)
      s_write(CMD_FW_REVISION) |=> cr_q.bad_cmd;
  endproperty
  a_fw_ro: assert property (p_fw_ro) else $error("firmware write not refused"); // [R8]

  property p_pins;
    @(posedge clk_i) disable iff (reset_i)
      pins_ok(cr_q.pin_cfg[3:0]);
  endproperty
  a_pins: assert property (p_pins) else $error("illegal pin code"); // [R11]

  property p_ignore_sec;
    @(posedge clk_i) disable iff (reset_i)
      (en_i && !cr_q.onoff[ONOFF_AND_BIT]) |=> (cr_q.output_on == $past(cr_q.pri));
  endproperty
  a_ignore_sec: assert property (p_ignore_sec) else $error("secondary not ignored"); // [R12]

  property p_pg_level;
    @(posedge clk_i) disable iff (reset_i)
      en_i |=> (cr_q.pg_level == ($past(cr_q.pg_pol) ~^ $past(power_ok_i)));
  endproperty
  a_pg_level: assert property (p_pg_level) else $error("power ok level wrong"); // [R14]

  property p_link_busy;
    @(posedge link_clk_i) disable iff (reset_i)
      (cmd_valid_i && !link_busy_o) |=> link_busy_o;
  endproperty
  a_link_busy: assert property (p_link_busy) else $error("command not captured");
endmodule

// ### rtl/pmbscr_pkg.sv
package pmbscr_pkg;
  // Command codes
  localparam logic [7:0] CMD_TEMP_STATUS   = 8'h7d;
  localparam logic [7:0] CMD_COMM_STATUS   = 8'h7e;
  localparam logic [7:0] CMD_VIN_READING   = 8'h88;
  localparam logic [7:0] CMD_VOUT_READING  = 8'h8b;
  localparam logic [7:0] CMD_IOUT_READING  = 8'h8c;
  localparam logic [7:0] CMD_TEMP_READING  = 8'h8d;
  localparam logic [7:0] CMD_MODULE_TYPE   = 8'hd0;
  localparam logic [7:0] CMD_VOUT_GAIN     = 8'hd1;
  localparam logic [7:0] CMD_VOUT_OFFSET   = 8'hd2;
  localparam logic [7:0] CMD_VIN_GAIN      = 8'hd3;
  localparam logic [7:0] CMD_VIN_OFFSET    = 8'hd4;
  localparam logic [7:0] CMD_IOUT_GAIN     = 8'hd6;
  localparam logic [7:0] CMD_IOUT_OFFSET   = 8'hd7;
  localparam logic [7:0] CMD_FW_REVISION   = 8'hdb;
  localparam logic [7:0] CMD_PIN_CONFIG    = 8'he0;
  localparam logic [7:0] CMD_ONOFF_COMBINE = 8'he1;
  localparam logic [7:0] CMD_POWER_OK_POL  = 8'he2;
  // Status bit positions
  localparam int TEMP_OT_FAULT_BIT  = 7;
  localparam int TEMP_OT_WARN_BIT   = 6;
  localparam int COMM_BAD_CMD_BIT   = 7;
  localparam int COMM_BAD_DATA_BIT  = 6;
  localparam int COMM_PEC_FAIL_BIT  = 5;
  // Module type word fields
  localparam int WP_BIT             = 1;
  localparam int DESIG_LSB          = 2;
  localparam logic WP_RESET         = 1'b1;
  // Pin configuration fields
  localparam int ARA_BIT            = 4;
  localparam logic [3:0] PINS_ONOFF_PG   = 4'h0;
  localparam logic [3:0] PINS_TRIM_PG    = 4'h1;
  localparam logic [3:0] PINS_TRIM_ONOFF = 4'h2;
  localparam logic [4:0] PIN_CFG_RESET   = 5'h00;
  // On/off combination and power-ok polarity
  localparam int ONOFF_AND_BIT      = 1;
  localparam int ONOFF_POL_BIT      = 0;
  localparam logic [1:0] ONOFF_RESET     = 2'h0;
  localparam logic PG_POL_RESET     = 1'b1;
  // Calibration limits and resets
  localparam logic [15:0] GAIN_MIN       = 16'h1999;
  localparam logic [15:0] GAIN_MAX       = 16'h2666;
  localparam logic [15:0] GAIN_RESET     = 16'h2000;
  localparam logic [4:0]  EXP_VOUT       = 5'h14;
  localparam logic [4:0]  EXP_VIN        = 5'h1d;
  localparam logic [4:0]  EXP_IOUT       = 5'h1c;
  localparam logic [10:0] OFFSET_MANT_RESET = 11'h000;
endpackage

// ### testbench/pmbscr_host.sv
`timescale 1ns/1ns
// Host controller on the management link
module pmbscr_host (
  // Link handshake
  input  wire logic        link_clk_i,
  input  wire logic        rsp_valid_i,
  // Command fields
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o,
  output logic             cmd_write_o,
  output logic [15:0]      cmd_data_o,
  output logic             cmd_pec_ok_o
);
  initial begin
    cmd_valid_o  = 1'b0;
    cmd_code_o   = 8'h00;
    cmd_write_o  = 1'b0;
    cmd_data_o   = 16'h0000;
    cmd_pec_ok_o = 1'b1;
  end

  // One command at a time; released code, data and PEC fields show inverted values
  task automatic xfer(input logic [7:0] code, input logic wr, input logic [15:0] data,
                      input logic pec);
    int n;
    n = 0;
    @(posedge link_clk_i);
    cmd_valid_o  <= 1'b1;
    cmd_code_o   <= code;
    cmd_write_o  <= wr;
    cmd_data_o   <= data;
    cmd_pec_ok_o <= pec;
    @(posedge link_clk_i);
    cmd_valid_o  <= 1'b0;
    cmd_code_o   <= ~code;
    cmd_data_o   <= ~data;
    cmd_pec_ok_o <= ~pec;
    while (rsp_valid_i !== 1'b1 && n < 16) begin
      @(posedge link_clk_i);
      n++;
    end
  endtask
endmodule

// ### testbench/pmbscr_test.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module pmbus_status_and_config_regs_test;
  import pmbscr_pkg::*;
  localparam logic [5:0] DES = 6'h2a; // Arbitrary value
  localparam logic [7:0] FW  = 8'h5c; // Arbitrary value
  localparam logic [7:0] MCMD [4] = '{CMD_VIN_READING, CMD_VOUT_READING,
                                      CMD_IOUT_READING, CMD_TEMP_READING};
  localparam logic [7:0] GCMD [3] = '{CMD_VOUT_GAIN, CMD_VIN_GAIN, CMD_IOUT_GAIN};
  localparam logic [7:0] OCMD [3] = '{CMD_VOUT_OFFSET, CMD_VIN_OFFSET, CMD_IOUT_OFFSET};
  localparam logic [4:0] OEXP [3] = '{EXP_VOUT, EXP_VIN, EXP_IOUT};
  logic        clk_i = 1'b0;
  logic        link_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        cmd_valid, cmd_write, cmd_pec_ok, rsp_valid, link_busy;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_data, rsp_data, g_vo, g_vi, g_io;
  logic [15:0] meas [4];
  logic [15:0] gval [3];
  logic        ot_f = 1'b0, ot_w = 1'b0, pok = 1'b0, alert = 1'b0;
  logic        prim = 1'b0, pin1 = 1'b0, pin2_drv = 1'b0, en = 1'b1;
  logic        pin2_o, pin2_oe, on_o, ara_o;
  wire logic   pin2;
  logic [4:0]  cfg;
  logic [7:0]  r;
  logic [10:0] m;
  logic [23:0] note;
  logic [23:0] notes [$];
  int          failures = 0, cmp_count = 0, cycles = 0, seed = 43;

  assign pin2 = pin2_oe ? pin2_o : pin2_drv;
  always #5 clk_i = ~clk_i;
  initial begin
    #37;
    forever #80 link_clk_i = ~link_clk_i;
  end

  pmbscr_regs #(.DESIGNATION(DES), .FW_REVISION(FW)) pmbscr_regs_inst (
    .clk_i(clk_i), .reset_i(reset_i), .en_i(en), .link_clk_i(link_clk_i),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_write_i(cmd_write),
    .cmd_data_i(cmd_data), .cmd_pec_ok_i(cmd_pec_ok), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .link_busy_o(link_busy), .vin_meas_i(meas[0]),
    .vout_meas_i(meas[1]), .iout_meas_i(meas[2]), .temp_meas_i(meas[3]),
    .ot_fault_evt_i(ot_f), .ot_warn_evt_i(ot_w), .power_ok_i(pok), .alert_i(alert),
    .primary_on_i(prim), .first_control_pin_i(pin1), .second_control_pin_i(pin2),
    .second_control_pin_o(pin2_o), .second_control_pin_oe_o(pin2_oe),
    .output_on_o(on_o), .ara_only_o(ara_o), .vout_gain_o(g_vo), .vin_gain_o(g_vi),
    .iout_gain_o(g_io));

  pmbscr_host pmbscr_host_inst (
    .link_clk_i(link_clk_i), .rsp_valid_i(rsp_valid), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .cmd_write_o(cmd_write), .cmd_data_o(cmd_data),
    .cmd_pec_ok_o(cmd_pec_ok));

  task automatic close_out();
    if (notes.size() != 0) begin
      failures++;
    end
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic pec = 1'b1);
    notes.push_back({c, 16'h0000});
    pmbscr_host_inst.xfer(c, 1'b1, d, pec);
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    notes.push_back({c, e});
    pmbscr_host_inst.xfer(c, 1'b0, 16'h0000, 1'b1);
  endtask

  // Combined enable from primary, pin map, combine mode and polarity
  function automatic logic exp_on(input logic [3:0] c, input logic [1:0] k, input logic p,
                                  input logic a, input logic b);
    logic s;
    s = (c == 4'h0) ? a : b;
    s = (c == 4'h1) ? 1'b1 : (k[0] ? s : ~s);
    return p & (~k[1] | s);
  endfunction

  // Answers are matched in order against the notes
  always @(posedge link_clk_i) begin
    if (rsp_valid === 1'b1) begin
      note = notes.pop_front();
      `CHK($sformatf("rsp_%h", note[23:16]), note[15:0], rsp_data)
    end
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (2) @(posedge link_clk_i);
    @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 4; i++)
      meas[i] <= 16'($random(seed));
    rd(CMD_VOUT_GAIN, GAIN_RESET);
    rd(CMD_VIN_GAIN, GAIN_RESET);
    rd(CMD_MODULE_TYPE, {8'h00, 1'b1, DES[4:0], 2'b10});
    rd(CMD_PIN_CONFIG, 16'h0000);
    rd(CMD_ONOFF_COMBINE, 16'h0000);
    rd(CMD_POWER_OK_POL, 16'h0001);
    rd(CMD_FW_REVISION, {8'h00, FW});
    for (int i = 0; i < 4; i++)
      rd(MCMD[i], meas[i]);
    // Locked calibration write
    wr(CMD_VOUT_GAIN, 16'h2100);
    rd(CMD_VOUT_GAIN, GAIN_RESET);
    rd(CMD_COMM_STATUS, 16'h0040);
    wr(CMD_COMM_STATUS, 16'h0040);
    rd(CMD_COMM_STATUS, 16'h0000);
    wr(CMD_MODULE_TYPE, 16'hfffd);
    rd(CMD_MODULE_TYPE, {8'h00, 1'b1, DES[4:0], 2'b00});
    for (int k = 0; k < 3; k++) begin
      gval[k] = GAIN_MIN + ($random(seed) & 16'h03ff);
      wr(GCMD[k], 16'h1998);
      wr(GCMD[k], GAIN_MIN);
      rd(GCMD[k], GAIN_MIN);
      wr(GCMD[k], 16'h2667);
      rd(GCMD[k], GAIN_MIN);
      wr(GCMD[k], GAIN_MAX);
      rd(GCMD[k], GAIN_MAX);
      wr(GCMD[k], gval[k]);
      m = $random(seed);
      wr(OCMD[k], {OEXP[k] + 5'h01, m});
      rd(OCMD[k], {OEXP[k], 11'h000});
      wr(OCMD[k], {OEXP[k], m});
      rd(OCMD[k], {OEXP[k], m});
      rd(CMD_COMM_STATUS, 16'h0040);
      wr(CMD_COMM_STATUS, 16'h00ff);
    end
    `CHK("vout_gain", gval[0], g_vo)
    `CHK("vin_gain", gval[1], g_vi)
    `CHK("iout_gain", gval[2], g_io)
    wr(CMD_MODULE_TYPE, 16'h0002);
    wr(CMD_IOUT_OFFSET, {EXP_IOUT, ~m});
    rd(CMD_IOUT_OFFSET, {EXP_IOUT, m});
    // Every communication fault kind
    wr(CMD_FW_REVISION, 16'h0001);
    wr(8'h55, 16'h0000);
    wr(CMD_PIN_CONFIG, 16'h0001, 1'b0);
    wr(CMD_PIN_CONFIG, 16'h0003);
    rd(CMD_PIN_CONFIG, 16'h0000);
    rd(CMD_FW_REVISION, {8'h00, FW});
    rd(CMD_COMM_STATUS, 16'h00e0);
    wr(CMD_COMM_STATUS, 16'h0080);
    rd(CMD_COMM_STATUS, 16'h0060);
    wr(CMD_COMM_STATUS, 16'h00ff);
    rd(CMD_COMM_STATUS, 16'h0000);
    // Temperature flags stick until cleared
    @(posedge clk_i);
    ot_f <= 1'b1;
    ot_w <= 1'b1;
    repeat (2) @(posedge clk_i);
    ot_f <= 1'b0;
    ot_w <= 1'b0;
    rd(CMD_TEMP_STATUS, 16'h00c0);
    wr(CMD_TEMP_STATUS, 16'h003f);
    rd(CMD_TEMP_STATUS, 16'h00c0);
    wr(CMD_TEMP_STATUS, 16'h0080);
    rd(CMD_TEMP_STATUS, 16'h0040);
    wr(CMD_TEMP_STATUS, 16'h0040);
    rd(CMD_TEMP_STATUS, 16'h0000);
    wr(CMD_ONOFF_COMBINE, 16'h00fc);
    rd(CMD_ONOFF_COMBINE, 16'h0000);
    wr(CMD_POWER_OK_POL, 16'h00fe);
    rd(CMD_POWER_OK_POL, 16'h0000);
    // Pin maps, combine modes and polarities
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      cfg = {r[0], 4'(i / 4)};
      wr(CMD_PIN_CONFIG, {8'h00, 3'b111, cfg});
      rd(CMD_PIN_CONFIG, {11'h000, cfg});
      wr(CMD_ONOFF_COMBINE, {14'h0000, 2'(i % 4)});
      wr(CMD_POWER_OK_POL, {15'h0000, r[1]});
      @(posedge clk_i);
      prim <= r[2];
      pin1 <= r[3];
      pin2_drv <= r[4];
      pok <= r[5];
      alert <= r[6];
      repeat (12) @(posedge clk_i);
      `CHK("output_on", exp_on(cfg[3:0], 2'(i % 4), r[2], r[3], r[4]), on_o)
      `CHK("pin2_oe", 1'(cfg[3:0] != 4'h2), pin2_oe)
      `CHK("ara_only", cfg[4] & r[6], ara_o)
      if (cfg[3:0] != 4'h2) begin
        `CHK("pin2_level", r[1] ~^ r[5], pin2_o)
      end
    end
    // Enable low freezes the combined output
    @(posedge clk_i);
    en <= 1'b0;
    prim <= ~prim;
    repeat (12) @(posedge clk_i);
    `CHK("on_frozen", exp_on(cfg[3:0], 2'h3, ~prim, pin1, pin2_drv), on_o)
    en <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK("on_resumed", exp_on(cfg[3:0], 2'h3, prim, pin1, pin2_drv), on_o)
    @(posedge link_clk_i);
    close_out();
  end
endmodule
